// >>> mic_intc.sv
/*
  Interrupt controller top: AHB-Lite register slave, pin edge
  detection, request flags, priority selection and exception sequencer.
  Assumes pins are asynchronous, peripheral inputs and the CPU
  instruction boundary strobe run on hclk, and one bus master.
*/
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module mic_intc (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Interrupt pins
  input  wire logic [4:0]           ext_pin,
  input  wire logic [7:0]           wake_pin,
  input  wire logic                 capture_input_pin,
  // Peripheral conditions
  input  wire mic_pkg::mic_periph_t periph,
  // CPU core
  input  wire logic                 insn_boundary,
  output mic_pkg::mic_exc_t         exc_q,
  output logic                      global_mask_q,
  output logic                      irq_pending_q
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]             req1_q, req2_q, wflag_q, wedge_q;
  logic [7:0]             en1_q, en2_q, wmode_q;
  logic [4:0]             eedge_q, emode_q;
  logic [7:0]             req1_d, req2_d, wflag_d;
  logic [7:0]             set1, set2, wset;
  logic [7:0]             clr1, clr2, wclr;
  logic                   wr_q;
  logic [7:0]             addr_q;
  logic                   addr_ph;
  logic [31:0]            rdata;
  logic                   wr_req1, wr_req2, wr_wflag, wr_ctrl;

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  // Only hsize word is used by the master; narrower sizes act the same
  assign addr_ph = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q   <= addr_ph & hwrite;
      addr_q <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    case (haddr)
      mic_pkg::MIC_OFF_REQ1:  rdata[7:0] = req1_q;
      mic_pkg::MIC_OFF_REQ2:  rdata[7:0] = req2_q;
      mic_pkg::MIC_OFF_WFLAG: rdata[7:0] = wflag_q;
      mic_pkg::MIC_OFF_WEDGE: rdata[7:0] = wedge_q;
      mic_pkg::MIC_OFF_EN1:   rdata[7:0] = en1_q;
      mic_pkg::MIC_OFF_EN2:   rdata[7:0] = en2_q;
      mic_pkg::MIC_OFF_EEDGE: rdata[4:0] = eedge_q;
      mic_pkg::MIC_OFF_EMODE: rdata[4:0] = emode_q;
      mic_pkg::MIC_OFF_WMODE: rdata[7:0] = wmode_q;
      mic_pkg::MIC_OFF_CTRL:  rdata[0]   = global_mask_q;
      mic_pkg::MIC_OFF_STAT:  rdata[7:0] = {irq_pending_q,
                                            exc_q.stacking |
                                            exc_q.vector_fetch |
                                            exc_q.insn_fetch |
                                            exc_q.internal_proc,
                                            1'b0, exc_q.vector};
      default:                rdata = 32'h0000_0000;
    endcase
  end

  // Read data is sampled in the address phase so it stands from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ph && !hwrite) begin
      hrdata <= rdata;
    end
  end

  assign wr_req1  = wr_q & (addr_q == mic_pkg::MIC_OFF_REQ1);
  assign wr_req2  = wr_q & (addr_q == mic_pkg::MIC_OFF_REQ2);
  assign wr_wflag = wr_q & (addr_q == mic_pkg::MIC_OFF_WFLAG);
  assign wr_ctrl  = wr_q & (addr_q == mic_pkg::MIC_OFF_CTRL);

  // ----------------------------------------------------------------
  // Plain read/write control registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wedge_q <= mic_pkg::MIC_RST_BYTE;
      en1_q   <= mic_pkg::MIC_RST_BYTE;
      en2_q   <= mic_pkg::MIC_RST_BYTE;
      eedge_q <= mic_pkg::MIC_RST_BYTE[4:0];
      emode_q <= mic_pkg::MIC_RST_BYTE[4:0];
      wmode_q <= mic_pkg::MIC_RST_BYTE;
    end else if (wr_q) begin
      case (addr_q)
        mic_pkg::MIC_OFF_WEDGE: wedge_q <= hwdata[7:0];
        mic_pkg::MIC_OFF_EN1:   en1_q   <= hwdata[7:0];
        mic_pkg::MIC_OFF_EN2:   en2_q   <= hwdata[7:0];
        mic_pkg::MIC_OFF_EEDGE: eedge_q <= hwdata[4:0];
        mic_pkg::MIC_OFF_EMODE: emode_q <= hwdata[4:0];
        mic_pkg::MIC_OFF_WMODE: wmode_q <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [4:0] ext_s1, ext_s2, ext_s3, ext_edge;
  logic [7:0] wk_s1, wk_s2, wk_s3, wk_edge;
  logic [2:0] cap_s;
  logic       cap_edge;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1 <= 5'h1f;
      ext_s2 <= 5'h1f;
      ext_s3 <= 5'h1f;
      wk_s1  <= 8'hff;
      wk_s2  <= 8'hff;
      wk_s3  <= 8'hff;
      cap_s  <= 3'h7;
    end else begin
      ext_s1 <= ext_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      wk_s1  <= wake_pin;
      wk_s2  <= wk_s1;
      wk_s3  <= wk_s2;
      cap_s  <= {cap_s[1:0], capture_input_pin};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_edge
      // falling when select is 0, rising when 1
      assign wk_edge[gi] = wedge_q[gi] ? (wk_s2[gi] & ~wk_s3[gi])
                                       : (~wk_s2[gi] & wk_s3[gi]);
      if (gi < 5) begin : g_ext
        assign ext_edge[gi] = eedge_q[gi] ? (ext_s2[gi] & ~ext_s3[gi])
                                          : (~ext_s2[gi] & ext_s3[gi]);
      end
    end
  endgenerate

  assign cap_edge = periph.capture_rise_sel ? (cap_s[1] & ~cap_s[2])
                                            : (~cap_s[1] & cap_s[2]);

  // ----------------------------------------------------------------
  // Timer condition detection
  // ----------------------------------------------------------------
  logic       mh_q, ml_q, m16_q;
  logic [7:0] tc_prev_q, ech_prev_q, ecl_prev_q;
  logic       mh, ml, m16, tc_wrap, ech_wrap, ecl_wrap, ec_wrap;

  assign mh  = periph.compare_counter_high == periph.compare_value_high;
  assign ml  = periph.compare_counter_low == periph.compare_value_low;
  assign m16 = mh & ml;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mh_q       <= 1'b1;
      ml_q       <= 1'b1;
      m16_q      <= 1'b1;
      tc_prev_q  <= 8'h00;
      ech_prev_q <= 8'h00;
      ecl_prev_q <= 8'h00;
    end else begin
      mh_q       <= mh;
      ml_q       <= ml;
      m16_q      <= m16;
      tc_prev_q  <= periph.updown_count;
      ech_prev_q <= periph.event_count_high;
      ecl_prev_q <= periph.event_count_low;
    end
  end

  assign tc_wrap =
    ((tc_prev_q == 8'hff) && (periph.updown_count == 8'h00)) ||
    ((tc_prev_q == 8'h00) && (periph.updown_count == 8'hff));
  assign ech_wrap = (ech_prev_q == 8'hff) &&
                    (periph.event_count_high == 8'h00);
  assign ecl_wrap = (ecl_prev_q == 8'hff) &&
                    (periph.event_count_low == 8'h00);
  // both bytes wrap in the same cycle in 16-bit mode, either byte in 8-bit mode
  assign ec_wrap  = periph.event_16bit ? (ech_wrap && ecl_wrap)
                                       : (ech_wrap || ecl_wrap);

  // ----------------------------------------------------------------
  // Request flag set and clear terms
  // ----------------------------------------------------------------
  always_comb begin
    set1 = 8'h00;
    set2 = 8'h00;
    // a condition only counts while enabled
    set1[mic_pkg::MIC_B_TA]  = periph.timer_a_ovf & en1_q[mic_pkg::MIC_B_TA];
    set1[mic_pkg::MIC_B_SER] = periph.serial_done &
                               en1_q[mic_pkg::MIC_B_SER];
    set1[4:0] = ext_edge & emode_q & en1_q[4:0];
    set2[mic_pkg::MIC_B_DT]  = periph.direct_xfer & en2_q[mic_pkg::MIC_B_DT];
    set2[mic_pkg::MIC_B_AD]  = periph.adc_done & en2_q[mic_pkg::MIC_B_AD];
    set2[mic_pkg::MIC_B_TG]  = ((cap_edge & periph.capture_pin_func) |
                                (periph.capture_ovf &
                                 periph.overflow_irq_enable)) &
                               en2_q[mic_pkg::MIC_B_TG];
    // byte match or word match by mode
    set2[mic_pkg::MIC_B_TFH] = (periph.compare_16bit ? (m16 & ~m16_q)
                                                     : (mh & ~mh_q)) &
                               en2_q[mic_pkg::MIC_B_TFH];
    set2[mic_pkg::MIC_B_TFL] = ~periph.compare_16bit & ml & ~ml_q &
                               en2_q[mic_pkg::MIC_B_TFL];
    set2[mic_pkg::MIC_B_TC]  = tc_wrap & en2_q[mic_pkg::MIC_B_TC];
    set2[mic_pkg::MIC_B_EC]  = ec_wrap & en2_q[mic_pkg::MIC_B_EC];
  end

  // wakeup pin in wakeup function, common enable on
  assign wset = wk_edge & wmode_q & {8{en1_q[mic_pkg::MIC_B_WAKE]}};

  // only zeros clear; ones leave flags alone
  assign clr1 = wr_req1  ? ~hwdata[7:0] : 8'h00;
  assign clr2 = wr_req2  ? ~hwdata[7:0] : 8'h00;
  assign wclr = wr_wflag ? ~hwdata[7:0] : 8'h00;

  // set beats a clear in the same cycle
  always_comb begin
    req1_d = (req1_q & ~clr1) | set1;
    req1_d[mic_pkg::MIC_B_FIX] = 1'b1;
    req2_d = (req2_q & ~clr2) | set2;
    // Reserved bit of the second request register is plain read/write
    if (wr_req2) begin
      req2_d[mic_pkg::MIC_B_FIX] = hwdata[mic_pkg::MIC_B_FIX];
    end
    wflag_d = (wflag_q & ~wclr) | wset;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req1_q  <= mic_pkg::MIC_RST_REQ1;
      req2_q  <= mic_pkg::MIC_RST_BYTE;
      wflag_q <= mic_pkg::MIC_RST_BYTE;
    end else begin
      req1_q  <= req1_d;
      req2_q  <= req2_d;
      wflag_q <= wflag_d;
    end
  end

  // ----------------------------------------------------------------
  // Priority selection
  // ----------------------------------------------------------------
  logic [mic_pkg::MIC_N_SRC-1:0] pend;
  logic [4:0]                    sel_vec;
  logic                          any_pend;

  // each flag gated by its enable; wake sources OR together
  assign pend = {req2_q[mic_pkg::MIC_B_DT] & en2_q[mic_pkg::MIC_B_DT],
                 req2_q[mic_pkg::MIC_B_AD] & en2_q[mic_pkg::MIC_B_AD],
                 req2_q[mic_pkg::MIC_B_EC] & en2_q[mic_pkg::MIC_B_EC],
                 req2_q[mic_pkg::MIC_B_TC] & en2_q[mic_pkg::MIC_B_TC],
                 req2_q[mic_pkg::MIC_B_TFL] & en2_q[mic_pkg::MIC_B_TFL],
                 req2_q[mic_pkg::MIC_B_TFH] & en2_q[mic_pkg::MIC_B_TFH],
                 req2_q[mic_pkg::MIC_B_TG] & en2_q[mic_pkg::MIC_B_TG],
                 req1_q[mic_pkg::MIC_B_SER] & en1_q[mic_pkg::MIC_B_SER],
                 req1_q[mic_pkg::MIC_B_TA] & en1_q[mic_pkg::MIC_B_TA],
                 (|wflag_q) & en1_q[mic_pkg::MIC_B_WAKE],
                 req1_q[4:0] & en1_q[4:0]};
  assign any_pend = |pend;

  // lowest index wins, the rest stay pending
  always_comb begin
    sel_vec = mic_pkg::MIC_SRC_VEC[0];
    for (int i = mic_pkg::MIC_N_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        sel_vec = mic_pkg::MIC_SRC_VEC[i];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pending_q <= 1'b0;
    end else begin
      irq_pending_q <= any_pend;
    end
  end

  // ----------------------------------------------------------------
  // Exception sequencer
  // ----------------------------------------------------------------
  mic_pkg::mic_state_t state_q, state_d;
  logic [1:0]          cnt_q, cnt_d;
  logic [4:0]          vec_q, vec_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    vec_d   = vec_q;
    case (state_q)
      mic_pkg::MIC_IDLE: begin
        if (any_pend && !global_mask_q) begin
          state_d = mic_pkg::MIC_WAIT;
          vec_d   = sel_vec;
        end
      end
      mic_pkg::MIC_WAIT: begin
        // latched request runs after the current instruction
        if (insn_boundary) begin
          state_d = mic_pkg::MIC_STACK;
          cnt_d   = 2'(mic_pkg::MIC_STACK_ST - 1);
        end
      end
      mic_pkg::MIC_STACK: begin
        if (cnt_q == 2'd0) begin
          state_d = mic_pkg::MIC_VFETCH;
          cnt_d   = 2'(mic_pkg::MIC_VFETCH_ST - 1);
        end else begin
          cnt_d = cnt_q - 2'd1;
        end
      end
      mic_pkg::MIC_VFETCH: begin
        if (cnt_q == 2'd0) begin
          state_d = mic_pkg::MIC_IFETCH;
          cnt_d   = 2'(mic_pkg::MIC_IFETCH_ST - 1);
        end else begin
          cnt_d = cnt_q - 2'd1;
        end
      end
      mic_pkg::MIC_IFETCH: begin
        if (cnt_q == 2'd0) begin
          state_d = mic_pkg::MIC_INTPR;
          cnt_d   = 2'(mic_pkg::MIC_INTPR_ST - 1);
        end else begin
          cnt_d = cnt_q - 2'd1;
        end
      end
      mic_pkg::MIC_INTPR: begin
        if (cnt_q == 2'd0) begin
          state_d = mic_pkg::MIC_IDLE;
        end else begin
          cnt_d = cnt_q - 2'd1;
        end
      end
      default: state_d = mic_pkg::MIC_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= mic_pkg::MIC_IDLE;
      cnt_q   <= 2'd0;
      vec_q   <= 5'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      vec_q   <= vec_d;
    end
  end

  // Outputs follow the next state so they line up with state_q
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exc_q <= '0;
    end else begin
      exc_q.stacking      <= state_d == mic_pkg::MIC_STACK;
      exc_q.vector_fetch  <= state_d == mic_pkg::MIC_VFETCH;
      exc_q.insn_fetch    <= state_d == mic_pkg::MIC_IFETCH;
      exc_q.internal_proc <= state_d == mic_pkg::MIC_INTPR;
      exc_q.handler_start <= (state_q == mic_pkg::MIC_INTPR) &&
                             (state_d == mic_pkg::MIC_IDLE);
      exc_q.vector        <= vec_d;
    end
  end

  // ----------------------------------------------------------------
  // Global mask bit
  // ----------------------------------------------------------------
  // mask set at exception start, winning over a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_mask_q <= mic_pkg::MIC_RST_MASK;
    end else if ((state_q == mic_pkg::MIC_WAIT) &&
                 (state_d == mic_pkg::MIC_STACK)) begin
      global_mask_q <= 1'b1;
    end else if (wr_ctrl) begin
      global_mask_q <= hwdata[mic_pkg::MIC_B_MASK];
    end
  end

endmodule

`default_nettype wire

// >>> mic_pkg.sv
/*
  Package for the interrupt controller: register offsets, field
  positions, reset values, exception sequence lengths, source vector
  table, sequencer states and the carrier structs.
  Assumes a single 200 MHz system clock; one CPU state is one cycle.
*/
`default_nettype none

package mic_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] MIC_OFF_REQ1  = 8'h00;
  localparam logic [7:0] MIC_OFF_REQ2  = 8'h04;
  localparam logic [7:0] MIC_OFF_WFLAG = 8'h08;
  localparam logic [7:0] MIC_OFF_WEDGE = 8'h0c;
  localparam logic [7:0] MIC_OFF_EN1   = 8'h10;
  localparam logic [7:0] MIC_OFF_EN2   = 8'h14;
  localparam logic [7:0] MIC_OFF_EEDGE = 8'h18;
  localparam logic [7:0] MIC_OFF_EMODE = 8'h1c;
  localparam logic [7:0] MIC_OFF_WMODE = 8'h20;
  localparam logic [7:0] MIC_OFF_CTRL  = 8'h24;
  localparam logic [7:0] MIC_OFF_STAT  = 8'h28;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MIC_RST_BYTE = 8'h00;
  localparam logic       MIC_RST_MASK = 1'b1;
  localparam logic [7:0] MIC_RST_REQ1 = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned MIC_B_TA   = 7;
  localparam int unsigned MIC_B_SER  = 6;
  localparam int unsigned MIC_B_FIX  = 5;
  localparam int unsigned MIC_B_DT   = 7;
  localparam int unsigned MIC_B_AD   = 6;
  localparam int unsigned MIC_B_TG   = 4;
  localparam int unsigned MIC_B_TFH  = 3;
  localparam int unsigned MIC_B_TFL  = 2;
  localparam int unsigned MIC_B_TC   = 1;
  localparam int unsigned MIC_B_EC   = 0;
  localparam int unsigned MIC_B_WAKE = 5;
  localparam int unsigned MIC_B_MASK = 0;
  localparam int unsigned MIC_N_EXT  = 5;
  localparam int unsigned MIC_N_WAKE = 8;
  localparam int unsigned MIC_N_SRC  = 15;

  // ----------------------------------------------------------------
  // Exception sequence lengths in states (cycles)
  // ----------------------------------------------------------------
  localparam int unsigned MIC_STACK_ST  = 4;
  localparam int unsigned MIC_VFETCH_ST = 2;
  localparam int unsigned MIC_IFETCH_ST = 4;
  localparam int unsigned MIC_INTPR_ST  = 4;

  // Vector per source, index 0 is the highest priority
  localparam logic [4:0] MIC_SRC_VEC [MIC_N_SRC] = '{
    5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0b, 5'h0d,
    5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};

  typedef enum logic [2:0] {
    MIC_IDLE   = 3'b000,
    MIC_WAIT   = 3'b001,
    MIC_STACK  = 3'b010,
    MIC_VFETCH = 3'b011,
    MIC_IFETCH = 3'b100,
    MIC_INTPR  = 3'b101
  } mic_state_t;

  // Peripheral condition inputs, all on the system clock
  typedef struct packed {
    logic       timer_a_ovf;
    logic       serial_done;
    logic       direct_xfer;
    logic       adc_done;
    logic       capture_pin_func;
    logic       capture_rise_sel;
    logic       capture_ovf;
    logic       overflow_irq_enable;
    logic       compare_16bit;
    logic [7:0] compare_counter_high;
    logic [7:0] compare_counter_low;
    logic [7:0] compare_value_high;
    logic [7:0] compare_value_low;
    logic [7:0] updown_count;
    logic       event_16bit;
    logic [7:0] event_count_high;
    logic [7:0] event_count_low;
  } mic_periph_t;

  // Exception sequence indication towards the CPU core
  typedef struct packed {
    logic       stacking;
    logic       vector_fetch;
    logic       insn_fetch;
    logic       internal_proc;
    logic       handler_start;
    logic [4:0] vector;
  } mic_exc_t;

endpackage

`default_nettype wire

// >>> mic_intc_assertions.sv
/*
  Port checker for the interrupt controller exception sequence.
  Assumes one clock, hclk, and the active-low reset hresetn.
*/
`timescale 1ns/1ps
`default_nettype none
module mic_intc_assertions (
  // Observed ports
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              insn_boundary,
  input wire mic_pkg::mic_exc_t exc_q,
  input wire logic              global_mask_q
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_stack_len: assert property (
    $rose(exc_q.stacking) |-> exc_q.stacking[*4] ##1 exc_q.vector_fetch)
    else $error("stacking length wrong");
  a_seq_rest: assert property (
    $rose(exc_q.vector_fetch) |-> exc_q.vector_fetch[*2] ##1
    exc_q.insn_fetch[*4] ##1 exc_q.internal_proc[*4] ##1
    exc_q.handler_start) else $error("fetch phases wrong");
  a_mask_entry: assert property (
    $rose(exc_q.stacking) |-> global_mask_q)
    else $error("mask not set on entry");
  a_after_boundary: assert property (
    $rose(exc_q.stacking) |-> $past(insn_boundary))
    else $error("stacking before instruction end");
  a_vec_legal: assert property (
    $rose(exc_q.stacking) |-> exc_q.vector inside {[5'h04:5'h14]})
    else $error("vector out of range");
  a_vec_stands: assert property (
    exc_q.internal_proc |=> $stable(exc_q.vector))
    else $error("vector moved during handling");
  a_start_pulse: assert property (
    exc_q.handler_start |=> !exc_q.handler_start)
    else $error("handler start too long");
  a_mask_held: assert property (
    (exc_q.stacking || exc_q.insn_fetch) |-> global_mask_q)
    else $error("mask low during exception");
endmodule
bind mic_intc mic_intc_assertions mic_intc_assertions_inst (
  .hclk(hclk), .hresetn(hresetn), .insn_boundary(insn_boundary),
  .exc_q(exc_q), .global_mask_q(global_mask_q));
`default_nettype wire

// >>> mic_cpu_model.sv
/*
  CPU core model: ends instructions of random length.
  Assumes the controller samples insn_boundary on hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module mic_cpu_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Towards the controller
  output var logic insn_boundary
);
  logic [3:0] cnt_q;
  // instructions of 1 to 13 states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q         <= 4'h1;
      insn_boundary <= 1'b0;
    end else if (cnt_q == 4'h1) begin
      cnt_q         <= 4'($urandom_range(13, 1));
      insn_boundary <= 1'b1;
    end else begin
      cnt_q         <= cnt_q - 4'h1;
      insn_boundary <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> mic_intc_tb_top.sv
/*
  Testbench: register bus, pin edges, timer wrap, exception entry.
  Assumes mic_intc and the CPU model; hready is tied to hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module mic_intc_tb_top;
  logic hclk, hresetn, hsel, hwrite, insn_boundary, hreadyout, hresp;
  logic global_mask_q, irq_pending_q, cap_pin;
  logic [7:0] haddr, wake_pin, r, e, m;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic [4:0] ext_pin, x;
  mic_pkg::mic_periph_t periph;
  mic_pkg::mic_exc_t exc_q;
  int fail_count, checks, n;
  mic_intc mic_intc_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_pin(ext_pin),
    .wake_pin(wake_pin), .capture_input_pin(cap_pin), .periph(periph),
    .insn_boundary(insn_boundary), .exc_q(exc_q),
    .global_mask_q(global_mask_q), .irq_pending_q(irq_pending_q));
  mic_cpu_model mic_cpu_model_inst (.hclk(hclk), .hresetn(hresetn),
    .insn_boundary(insn_boundary));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Write-zero-to-clear: a one leaves the flag alone
  function automatic logic [7:0] wc(input logic [7:0] o, input logic [7:0] w);
    return o & w;
  endfunction
  task hw;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail_count++;
        end_sim();
      end
      @(posedge hclk);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hw();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    hw();
    r = hrdata[7:0];
  endtask
  // Pin edge reaches its flag within four cycles
  task settle;
    repeat (6) @(posedge hclk);
  endtask
  // Bounded wait for the one-cycle handler start pulse
  task wait_start;
    n = 0;
    while (exc_q.handler_start !== 1'b1) begin
      @(posedge hclk);
      n++;
      if (n > 200) begin
        fail_count++;
        end_sim();
      end
    end
  endtask
  initial begin
    {hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'b010;
    periph = '0;
    ext_pin = 5'h1f;
    wake_pin = 8'hff;
    cap_pin = 1'b1;
    hresetn = 1'b0;
    fail_count = 0;
    checks = 0;
    void'($urandom(49));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, 8'h30, 8'h00);
    chk(r, 8'h00);
    bus(0, mic_pkg::MIC_OFF_WEDGE, 8'h00);
    chk(r, 8'h00);
    e = 8'($urandom);
    bus(1, mic_pkg::MIC_OFF_WEDGE, e);
    bus(0, mic_pkg::MIC_OFF_WEDGE, 8'h00);
    chk(r, e);
    bus(1, mic_pkg::MIC_OFF_WMODE, 8'hff);
    m = 8'($urandom);
    for (int i = 0; i < 2; i++) begin
      bus(1, mic_pkg::MIC_OFF_EN1, i ? 8'h00 : 8'h20);
      wake_pin <= ~e;
      settle();
      bus(1, mic_pkg::MIC_OFF_WFLAG, 8'h00);
      wake_pin <= e;
      settle();
      bus(0, mic_pkg::MIC_OFF_WFLAG, 8'h00);
      chk(r, i ? 8'h00 : 8'hff);
      // All flags are set here, so the random write really clears some
      if (i == 0) begin
        bus(1, mic_pkg::MIC_OFF_WFLAG, m);
        bus(0, mic_pkg::MIC_OFF_WFLAG, 8'h00);
        chk(r, wc(8'hff, m));
      end
    end
    x = 5'($urandom);
    bus(1, mic_pkg::MIC_OFF_EEDGE, {3'b000, x});
    bus(1, mic_pkg::MIC_OFF_EMODE, 8'h1f);
    bus(1, mic_pkg::MIC_OFF_EN1, 8'h1f);
    ext_pin <= ~x;
    settle();
    bus(1, mic_pkg::MIC_OFF_REQ1, 8'h00);
    ext_pin <= x;
    settle();
    bus(0, mic_pkg::MIC_OFF_REQ1, 8'h00);
    chk(r, 8'h3f);
    periph.updown_count <= 8'hff;
    settle();
    bus(1, mic_pkg::MIC_OFF_EN2, 8'h02);
    for (int i = 0; i < 2; i++) begin
      periph.updown_count <= ~periph.updown_count;
      settle();
      bus(0, mic_pkg::MIC_OFF_REQ2, 8'h00);
      chk(r, 8'h02);
      bus(1, mic_pkg::MIC_OFF_REQ2, 8'h00);
    end
    // Capture pin fall, byte matches and low event byte wrap together
    periph.capture_pin_func <= 1'b1;
    periph.compare_value_high <= 8'h5a;
    periph.compare_value_low <= 8'ha5;
    periph.event_count_low <= 8'hff;
    bus(1, mic_pkg::MIC_OFF_EN2, 8'h1f);
    cap_pin <= 1'b0;
    periph.compare_counter_high <= 8'h5a;
    periph.compare_counter_low <= 8'ha5;
    periph.event_count_low <= 8'h00;
    settle();
    bus(0, mic_pkg::MIC_OFF_REQ2, 8'h00);
    chk(r, 8'h1d);
    chk({3'b000, exc_q.vector}, 8'h00);
    bus(1, mic_pkg::MIC_OFF_CTRL, 8'h00);
    wait_start();
    chk({3'b000, exc_q.vector}, 8'h04);
    chk({7'h00, global_mask_q}, 8'h01);
    bus(0, mic_pkg::MIC_OFF_REQ1, 8'h00);
    chk(r, 8'h3f);
    bus(0, mic_pkg::MIC_OFF_STAT, 8'h00);
    chk(r, 8'h84);
    chk({7'h00, irq_pending_q}, 8'h01);
    chk({7'h00, hresp}, 8'h00);
    // Only wake enabled in the first register; second still 1f: wake must win over its internal flags
    bus(1, mic_pkg::MIC_OFF_EN1, 8'h20);
    wake_pin <= ~e;
    settle();
    wake_pin <= e;
    settle();
    bus(1, mic_pkg::MIC_OFF_CTRL, 8'h00);
    wait_start();
    chk({3'b000, exc_q.vector}, 8'h09);
    end_sim();
  end
endmodule
`default_nettype wire
